// [rtl/step_drum_sequencer.sv]
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module step_drum_sequencer #(
  parameter int unsigned SCAN_CYCLES = seq_pkg::SCAN_CYCLES,
  parameter int unsigned HUND_CYCLES = seq_pkg::HUND_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        start_in,
  input  wire logic        jog_in,
  input  wire logic        reset_in,
  input  wire logic [15:0] event_in,
  output logic      [15:0] seq_out,
  output logic             done_out
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Step numbers run 1..16, table rows 0..15
  function automatic logic [3:0] step_idx(input logic [4:0] step);
    logic [4:0] row;
    row      = step - seq_pkg::STEP_MIN;
    step_idx = row[3:0];
  endfunction

  // A step number is legal only between the first and last step
  function automatic logic step_ok(input logic [15:0] v);
    step_ok = (v >= 16'(seq_pkg::STEP_MIN)) && (v <= 16'(seq_pkg::STEP_MAX));
  endfunction

  // ****************************************************************
  // Scan and timebase enables
  // ****************************************************************

  logic scan_en;    // One pulse per controller scan
  logic hund_tick;  // One pulse per hundredth of a second

  pulse_divider #(
    .DIV     (SCAN_CYCLES)
  ) u_scan_div (
    .clk     (clk),
    .rst_n   (rst_n),
    .pulse_q (scan_en)
  );

  pulse_divider #(
    .DIV     (HUND_CYCLES)
  ) u_hund_div (
    .clk     (clk),
    .rst_n   (rst_n),
    .pulse_q (hund_tick)
  );

  // ****************************************************************
  // State
  // ****************************************************************

  logic        run_q, run_prev_q;      // Run mode and its value at last scan
  logic        evt_mode_q;             // Event variant when set, timed when clear
  logic        self_rst_q;             // Done flag fed back into reset
  logic [4:0]  preset_q;               // Preset step number
  logic [4:0]  step_q, step_d;         // Current step number
  logic [15:0] counts_q, counts_d;     // Counts in the current step
  logic [15:0] timer_q, timer_d;       // Hundredths inside the current count
  logic        done_q, done_d;         // Cycle complete flag
  logic [15:0] tbase_q;                // Hundredths per count
  logic        pend_q;                 // Hundredth waiting for the next scan
  logic        jog_prev_q;             // Jog level at last scan
  logic [15:0] out_d;                  // Next output pattern
  logic [15:0] pat_q  [seq_pkg::STEPS];  // Output pattern per step
  logic [15:0] cps_q  [seq_pkg::STEPS];  // Counts per step
  logic [4:0]  evt_q  [seq_pkg::STEPS];  // Event enable and input select
  logic [15:0] mask_q [seq_pkg::STEPS];  // Output write mask per step

  // ****************************************************************
  // Register decode
  // ****************************************************************

  wire [3:0] area     = reg_addr[7:4];
  wire [3:0] ofs      = reg_addr[3:0];
  wire       wr_core  = reg_wr && (area == seq_pkg::AREA_CORE);
  wire       wr_ctrl  = wr_core && (ofs == seq_pkg::OFS_CTRL);
  wire       wr_tbase = wr_core && (ofs == seq_pkg::OFS_TBASE)
                        && (reg_wdata <= seq_pkg::VALUE_MAX);
  wire       wr_pre   = wr_core && (ofs == seq_pkg::OFS_PRESET) && step_ok(reg_wdata);
  wire       wr_cur   = wr_core && (ofs == seq_pkg::OFS_CURSTEP) && step_ok(reg_wdata);
  wire       wr_pat   = reg_wr && (area == seq_pkg::AREA_PAT);
  wire       wr_cps   = reg_wr && (area == seq_pkg::AREA_CPS)
                        && (reg_wdata <= seq_pkg::VALUE_MAX);
  wire       wr_evt   = reg_wr && (area == seq_pkg::AREA_EVT);
  wire       wr_mask  = reg_wr && (area == seq_pkg::AREA_MASK);

  // ****************************************************************
  // Step decisions for one scan
  // ****************************************************************

  wire [3:0]  cur_idx   = step_idx(step_q);
  wire [15:0] cur_cps   = cps_q[cur_idx];
  wire [4:0]  cur_evt   = evt_q[cur_idx];
  wire        evt_true  = !cur_evt[seq_pkg::EVT_EN_BIT] || event_in[cur_evt[3:0]];
  wire        evt_ok    = !evt_mode_q || evt_true;
  wire        run_entry = run_q && !run_prev_q;
  wire        rst_eff   = reset_in || (self_rst_q && done_q);
  wire        jog_edge  = evt_mode_q && jog_in && !jog_prev_q;
  wire        timing    = start_in && evt_ok && !done_q;
  wire        count_hit = (counts_q == cur_cps);
  wire        advance   = !done_q && (jog_edge || (timing && count_hit));
  wire        last_step = (step_q == seq_pkg::STEP_MAX);
  wire [16:0] timer_nx  = {1'b0, timer_q} + 17'h00001;
  wire        count_end = (timer_nx >= {1'b0, tbase_q});

  // Next step, counters and flag, taken only on a scan in run mode
  always_comb begin
    step_d   = step_q;
    counts_d = counts_q;
    timer_d  = timer_q;
    done_d   = done_q;
    if (run_entry || rst_eff) begin
      step_d   = preset_q;
      counts_d = seq_pkg::WORD_ZERO;
      timer_d  = seq_pkg::WORD_ZERO;
      done_d   = 1'b0;
    end else if (advance) begin
      counts_d = seq_pkg::WORD_ZERO;
      timer_d  = seq_pkg::WORD_ZERO;
      if (last_step) begin
        done_d = 1'b1;
      end else begin
        step_d = step_q + 5'h01;
      end
    end else if (timing && pend_q) begin
      if (count_end) begin
        timer_d  = seq_pkg::WORD_ZERO;
        counts_d = counts_q + 16'h0001;
      end else begin
        timer_d  = timer_nx[15:0];
      end
    end
  end

  // Pattern of the step being entered, written through the mask
  wire [3:0]  nx_idx  = step_idx(step_d);
  wire [15:0] nx_pat  = pat_q[nx_idx];
  wire [15:0] nx_mask = mask_q[nx_idx];

  assign out_d = (nx_pat & nx_mask) | (seq_out & ~nx_mask);

  wire scan_run = scan_en && run_q;

  // ****************************************************************
  // Control and step registers
  // ****************************************************************

  // Control bits written by software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q      <= 1'b0;
      evt_mode_q <= 1'b0;
      self_rst_q <= 1'b0;
    end else if (wr_ctrl) begin
      run_q      <= reg_wdata[seq_pkg::CTRL_RUN_BIT];
      evt_mode_q <= reg_wdata[seq_pkg::CTRL_EVENT_BIT];
      self_rst_q <= reg_wdata[seq_pkg::CTRL_SELF_BIT];
    end
  end

  // Run and jog history move only on scans, so edges are seen per scan
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_prev_q <= 1'b0;
      jog_prev_q <= 1'b0;
    end else if (scan_en) begin
      run_prev_q <= run_q;
      jog_prev_q <= jog_in;
    end
  end

  // Timebase setting and preset step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tbase_q  <= seq_pkg::WORD_ZERO;
      preset_q <= seq_pkg::PRESET_RST;
    end else begin
      if (wr_tbase) begin
        tbase_q <= reg_wdata;
      end
      if (wr_pre) begin
        preset_q <= reg_wdata[4:0];
      end
    end
  end

  // A hundredth waits for the scan; a tick in the scan cycle is kept
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= hund_tick || (pend_q && !scan_en);
    end
  end

  // Step state; a software step write wins and restarts the step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_q   <= seq_pkg::PRESET_RST;
      counts_q <= seq_pkg::WORD_ZERO;
      timer_q  <= seq_pkg::WORD_ZERO;
      done_q   <= 1'b0;
    end else if (wr_cur) begin
      step_q   <= reg_wdata[4:0];
      counts_q <= seq_pkg::WORD_ZERO;
      timer_q  <= seq_pkg::WORD_ZERO;
    end else if (scan_run) begin
      step_q   <= step_d;
      counts_q <= counts_d;
      timer_q  <= timer_d;
      done_q   <= done_d;
    end
  end

  // seq_out written on every scan in run mode; done_out follows done_q every cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_out  <= seq_pkg::WORD_ZERO;
      done_out <= 1'b0;
    end else begin
      if (scan_run) begin
        seq_out <= out_d;
      end
      done_out <= done_q;
    end
  end

  // ****************************************************************
  // Step tables
  // ****************************************************************

  // One writable row per step in each table
  generate
    for (genvar i = 0; i < seq_pkg::STEPS; i++) begin : g_row
      wire hit = (ofs == 4'(i));
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pat_q[i]  <= seq_pkg::WORD_ZERO;
          cps_q[i]  <= seq_pkg::WORD_ZERO;
          evt_q[i]  <= seq_pkg::EVT_RST;
          mask_q[i] <= seq_pkg::MASK_RST;
        end else if (hit) begin
          if (wr_pat) begin
            pat_q[i] <= reg_wdata;
          end
          if (wr_cps) begin
            cps_q[i] <= reg_wdata;
          end
          if (wr_evt) begin
            evt_q[i] <= reg_wdata[4:0];
          end
          if (wr_mask) begin
            mask_q[i] <= reg_wdata;
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Read port
  // ****************************************************************

  logic [15:0] core_rd;  // Core register selected by offset
  logic [15:0] rd_val;   // Value for the addressed register

  always_comb begin
    unique case (ofs)
      seq_pkg::OFS_COUNTS:  core_rd = counts_q;
      seq_pkg::OFS_TIMER:   core_rd = timer_q;
      seq_pkg::OFS_PRESET:  core_rd = {11'h000, preset_q};
      seq_pkg::OFS_CURSTEP: core_rd = {11'h000, step_q};
      seq_pkg::OFS_CTRL:    core_rd = {13'h0000, self_rst_q, evt_mode_q, run_q};
      seq_pkg::OFS_STATUS:  core_rd = {15'h0000, done_q};
      seq_pkg::OFS_TBASE:   core_rd = tbase_q;
      default:              core_rd = seq_pkg::WORD_ZERO;
    endcase
  end

  // Unmapped areas read as zero
  always_comb begin
    unique case (area)
      seq_pkg::AREA_CORE: rd_val = core_rd;
      seq_pkg::AREA_PAT:  rd_val = pat_q[ofs];
      seq_pkg::AREA_CPS:  rd_val = cps_q[ofs];
      seq_pkg::AREA_EVT:  rd_val = {11'h000, evt_q[ofs]};
      seq_pkg::AREA_MASK: rd_val = mask_q[ofs];
      default:            rd_val = seq_pkg::WORD_ZERO;
    endcase
  end

  // Read data stand in the cycle after the strobe only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= seq_pkg::WORD_ZERO;
    end else begin
      reg_rdata <= reg_rd ? rd_val : seq_pkg::WORD_ZERO;
    end
  end

endmodule

// [rtl/seq_pkg.sv]
// ****************************************************************
// Shared constants of the step sequencer
// ****************************************************************
package seq_pkg;

  // Geometry of the drum
  localparam int          STEPS     = 16;
  localparam int          WORD_W    = 16;
  localparam int          STEP_W    = 5;
  localparam int          IDX_W     = 4;
  localparam int          ADDR_W    = 8;

  // Address areas, upper nibble of the register address
  localparam logic [3:0]  AREA_CORE = 4'h0;
  localparam logic [3:0]  AREA_PAT  = 4'h1;
  localparam logic [3:0]  AREA_CPS  = 4'h2;
  localparam logic [3:0]  AREA_EVT  = 4'h3;
  localparam logic [3:0]  AREA_MASK = 4'h4;

  // Core register offsets, lower nibble; first two are the status counters
  localparam logic [3:0]  OFS_COUNTS  = 4'h0;
  localparam logic [3:0]  OFS_TIMER   = 4'h1;
  localparam logic [3:0]  OFS_PRESET  = 4'h2;
  localparam logic [3:0]  OFS_CURSTEP = 4'h3;
  localparam logic [3:0]  OFS_CTRL    = 4'h4;
  localparam logic [3:0]  OFS_STATUS  = 4'h5;
  localparam logic [3:0]  OFS_TBASE   = 4'h6;

  // Field positions
  localparam int          CTRL_RUN_BIT   = 0;
  localparam int          CTRL_EVENT_BIT = 1;
  localparam int          CTRL_SELF_BIT  = 2;
  localparam int          STAT_DONE_BIT  = 0;
  localparam int          EVT_EN_BIT     = 4;

  // Legal ranges
  localparam logic [4:0]  STEP_MIN  = 5'h01;
  localparam logic [4:0]  STEP_MAX  = 5'h10;
  localparam logic [15:0] VALUE_MAX = 16'h270F;

  // Reset values
  localparam logic [4:0]  PRESET_RST = 5'h01;
  localparam logic [15:0] MASK_RST   = 16'hFFFF;
  localparam logic [15:0] WORD_ZERO  = 16'h0000;
  localparam logic [4:0]  EVT_RST    = 5'h00;

  // Timing: one timer unit is a hundredth of a second, one scan a millisecond
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned HUND_TIME_NS  = 10_000_000;
  localparam int unsigned SCAN_TIME_NS  = 1_000_000;
  localparam int unsigned HUND_CYCLES   = HUND_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SCAN_CYCLES   = SCAN_TIME_NS / CLK_PERIOD_NS;

endpackage

// [rtl/pulse_divider.sv]
`timescale 1ns/1ps
// ****************************************************************
// Free running divider giving a one-cycle enable pulse
// ****************************************************************
module pulse_divider #(
  parameter int unsigned DIV = 2
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      pulse_q
);

  localparam int          CW   = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;   // Cycle position inside one period
  logic          wrap;    // Last cycle of the period

  assign wrap = (cnt_q == LAST);

  // Count and pulse on the wrap so the enable is one cycle wide
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q   <= '0;
      pulse_q <= 1'b0;
    end else begin
      cnt_q   <= wrap ? '0 : cnt_q + 1'b1;
      pulse_q <= wrap;
    end
  end

endmodule

// [verification/step_drum_sequencer_asserts.sv]
`timescale 1ns/1ps
// ****************************************
// Port checks of the step sequencer
// ****************************************
module step_drum_sequencer_asserts #(
  parameter int unsigned SCAN_CYCLES = 16,
  parameter int unsigned HUND_CYCLES = 4
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        start_in,
  input wire logic        jog_in,
  input wire logic        reset_in,
  input wire logic [15:0] event_in,
  input wire logic [15:0] seq_out,
  input wire logic        done_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  int hold_q;  // Cycles reset_in has stayed high
  // Saturate so a long reset hold never wraps back to a small count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hold_q <= 0;
    else if (!reset_in) hold_q <= 0;
    else if (hold_q < 255) hold_q <= hold_q + 1;
  end
  // Reads of the two writable step counters
  sequence rd_preset; reg_rd && reg_addr == 8'h02; endsequence
  sequence rd_step; reg_rd && reg_addr == 8'h03; endsequence
  rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read answer");
  unmapped_zero_a: assert property (reg_rd && reg_addr == 8'h7F |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  preset_range_a: assert property (rd_preset |=> reg_rdata inside {[16'h0001:16'h0010]})
    else $error("preset step out of range");
  step_range_a: assert property (rd_step |=> reg_rdata inside {[16'h0001:16'h0010]})
    else $error("current step out of range");
  status_bits_a: assert property (reg_rd && reg_addr == 8'h05 |=> reg_rdata[15:1] == 15'h0000)
    else $error("unused status bits set");
  counts_range_a: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata <= 16'h270F)
    else $error("counts in step above limit");
  out_per_scan_a: assert property ($changed(seq_out) |=> $stable(seq_out) [*8])
    else $error("outputs changed twice within a scan");
  done_step_a: assert property (rd_step ##1 done_out |-> reg_rdata == 16'h0010)
    else $error("step not 16 while complete");
  reset_clear_a: assert property (hold_q > SCAN_CYCLES + 3 |-> !done_out)
    else $error("complete flag survives reset");
endmodule

bind step_drum_sequencer step_drum_sequencer_asserts #(
  .SCAN_CYCLES(SCAN_CYCLES), .HUND_CYCLES(HUND_CYCLES)
) u_asserts (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_in(start_in), .jog_in(jog_in),
  .reset_in(reset_in), .event_in(event_in), .seq_out(seq_out), .done_out(done_out)
);

// [verification/ladder_ctrl.sv]
`timescale 1ns/1ps
// ****************************************
// Control rungs in front of the sequencer
// ****************************************
module ladder_ctrl (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        start_req,  // Wanted start level
  input  wire logic        jog_req,    // Wanted jog level
  input  wire logic        man_reset,  // Manual reset contact
  input  wire logic        loop_en,    // Feed complete flag back
  input  wire logic [15:0] evt_req,    // Event contacts
  input  wire logic        prev_done,  // Done of a preceding stage
  input  wire logic        done_out,
  output logic             start_in,
  output logic             jog_in,
  output logic             reset_in,
  output logic      [15:0] event_in
);
  // Rungs solve once a clock, so each level lags its request by one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_in <= 1'b0;
      jog_in   <= 1'b0;
      reset_in <= 1'b0;
      event_in <= 16'h0000;
    end else begin
      // following stage starts on preceding done
      start_in <= start_req | prev_done;
      jog_in   <= jog_req;
      reset_in <= man_reset | (loop_en & done_out);
      event_in <= evt_req;
    end
  end
endmodule

// [verification/step_drum_sequencer_tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", nm, ex, got); end end
module step_drum_sequencer_tb_top;
  // ****************************************
  // Signals
  // ****************************************
  localparam int unsigned SC = 16;  // Short scan keeps the run brief
  localparam int unsigned HC = 4;   // Hundredth shorter than a scan
  logic        clk;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        start_req;
  logic        jog_req;
  logic        man_reset;
  logic        loop_en;
  logic [15:0] evt_req;
  logic        prev_done;    // Stand-in for a preceding stage's done
  logic        start_in;
  logic        jog_in;
  logic        reset_in;
  logic [15:0] event_in;
  logic [15:0] seq_out;
  logic        done_out;
  logic [15:0] rdv;          // Last value read
  int          n;            // Cycles spent waiting
  int          fail_count;
  int          checks_done;
  step_drum_sequencer #(.SCAN_CYCLES(SC), .HUND_CYCLES(HC)) dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_in(start_in),
    .jog_in(jog_in), .reset_in(reset_in), .event_in(event_in), .seq_out(seq_out),
    .done_out(done_out)
  );
  ladder_ctrl u_ctrl (
    .clk(clk), .rst_n(rst_n), .start_req(start_req), .jog_req(jog_req),
    .man_reset(man_reset), .loop_en(loop_en), .evt_req(evt_req), .done_out(done_out),
    .prev_done(prev_done),
    .start_in(start_in), .jog_in(jog_in), .reset_in(reset_in), .event_in(event_in)
  );
  // ****************************************
  // Helpers
  // ****************************************
  // Distinct pattern per step so a wrong step shows on the outputs
  function automatic logic [15:0] pat(input logic [4:0] s);
    return {11'h528, s};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 rdv = reg_rdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] ex, input string nm);
    rd(a);
    `CHK(nm, ex, rdv)
  endtask
  task automatic scans(input int k);
    repeat (k * SC) @(posedge clk);
    #1;
  endtask
  // Levels are held two scans so a scan surely samples them
  task automatic jog();
    jog_req <= 1'b1;
    scans(2);
    jog_req <= 1'b0;
    scans(2);
  endtask
  task automatic wait_done(input logic lvl, input int lim);
    n = 0;
    while (done_out !== lvl && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("done_out", lvl, done_out)
  endtask
  task automatic conclude();
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    `CHK("seq_out", 16'h0000, seq_out)
    rdchk(8'h02, 16'h0001, "preset");
    rdchk(8'h03, 16'h0001, "step");
    rdchk(8'h40, 16'hFFFF, "mask");
    wr(8'h00, 16'h1234);
    wr(8'h01, 16'h4321);
    rdchk(8'h00, 16'h0000, "counts");
    rdchk(8'h01, 16'h0000, "timer");
    rdchk(8'h7F, 16'h0000, "unmapped");
  endtask
  task automatic t_setup();
    for (int i = 0; i < 16; i++) begin
      // step one is an idle step, outputs off
      wr({4'h1, 4'(i)}, (i == 0) ? 16'h0000 : pat(5'(i + 1)));
      wr({4'h2, 4'(i)}, 16'h0000);
      wr({4'h3, 4'(i)}, 16'h0000);
    end
    wr(8'h06, 16'h0000);
  endtask
  task automatic t_range();
    wr(8'h02, 16'h0000);
    rdchk(8'h02, 16'h0001, "preset low");
    wr(8'h02, 16'h0011);
    rdchk(8'h02, 16'h0001, "preset high");
    wr(8'h02, 16'h0010);
    rdchk(8'h02, 16'h0010, "preset max");
    wr(8'h02, 16'h0003);
  endtask
  // Run entry with start off: preset pattern, then frozen; timed jog ignored
  task automatic t_entry();
    wr(8'h04, 16'h0001);
    scans(2);
    `CHK("entry out", pat(5'h03), seq_out)
    rdchk(8'h03, 16'h0003, "entry step");
    scans(3);
    `CHK("held out", pat(5'h03), seq_out)
    rdchk(8'h03, 16'h0003, "frozen");
    jog();
    rdchk(8'h03, 16'h0003, "timed jog");
  endtask
  task automatic t_sweep();
    start_req <= 1'b1;
    wait_done(1'b1, 16 * SC);
    `CHK("per scan", 1'b1, n >= 13 * SC && n <= 14 * SC + 4)
    rdchk(8'h03, 16'h0010, "last step");
    rdchk(8'h05, 16'h0001, "status done");
    `CHK("last out", pat(5'h10), seq_out)
    scans(2);
    `CHK("done held", 1'b1, done_out)
    man_reset <= 1'b1;
    scans(2);
    `CHK("done clr", 1'b0, done_out)
    rdchk(8'h03, 16'h0003, "reset step");
    man_reset <= 1'b0;
    start_req <= 1'b0;
  endtask
  task automatic t_count();
    wr(8'h22, 16'h0002);
    wr(8'h23, 16'h270F);
    start_req <= 1'b1;
    scans(1);
    rdchk(8'h03, 16'h0003, "counting");
    scans(4);
    rdchk(8'h03, 16'h0004, "count met");
    start_req <= 1'b0;
  endtask
  task automatic t_event();
    wr(8'h04, 16'h0003);
    wr(8'h03, 16'h0006);
    rdchk(8'h03, 16'h0006, "step write");
    wr(8'h35, 16'h0015);
    wr(8'h26, 16'h270F);
    start_req <= 1'b1;
    scans(3);
    rdchk(8'h03, 16'h0006, "event low");
    evt_req <= 16'h0020;
    scans(2);
    rdchk(8'h03, 16'h0007, "event high");
    scans(2);
    rd(8'h00);
    `CHK("blank runs", 1'b1, rdv > 16'h0000)
    start_req <= 1'b0;
    evt_req   <= 16'h0000;
    jog();
    rdchk(8'h03, 16'h0008, "jog");
  endtask
  // Outside loop first, then the internal self-reset bit
  task automatic t_self();
    for (int m = 0; m < 2; m++) begin
      wr(8'h02, 16'h000F);
      man_reset <= 1'b1;
      scans(2);
      man_reset <= 1'b0;
      loop_en   <= (m == 0);
      wr(8'h04, (m == 0) ? 16'h0003 : 16'h0007);
      if (m == 0) begin
        // start from a finished preceding stage
        prev_done <= 1'b1;
      end else begin
        start_req <= 1'b1;
      end
      wait_done(1'b1, 4 * SC);
      wait_done(1'b0, 2 * SC);
      start_req <= 1'b0;
      prev_done <= 1'b0;
      loop_en   <= 1'b0;
    end
    wr(8'h04, 16'h0003);
  endtask
  // Idle preset step clears the outputs, then masked bits hold their state
  task automatic t_mask();
    wr(8'h02, 16'h0001);
    man_reset <= 1'b1;
    scans(2);
    man_reset <= 1'b0;
    `CHK("idle out", 16'h0000, seq_out)
    wr(8'h40, 16'h00FF);
    wr(8'h10, 16'hFFFF);
    scans(2);
    `CHK("masked out", 16'h00FF, seq_out)
    wr(8'h40, 16'hFF00);
    wr(8'h10, 16'h0000);
    scans(2);
    `CHK("kept out", 16'h00FF, seq_out)
  endtask
  // ****************************************
  // Clock, sequence and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    rst_n       = 1'b0;
    reg_addr    = 8'h00;
    reg_wdata   = 16'h0000;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    start_req   = 1'b0;
    jog_req     = 1'b0;
    man_reset   = 1'b0;
    loop_en     = 1'b0;
    prev_done   = 1'b0;
    evt_req     = 16'h0000;
    fail_count  = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_setup();
    t_range();
    t_entry();
    t_sweep();
    t_count();
    t_event();
    t_self();
    t_mask();
    conclude();
  end
  // Whole run is near twelve hundred cycles; ten thousand means a hang
  initial begin
    #40000;
    fail_count++;
    conclude();
  end
endmodule
